// file: crce_engine.v
// crc engine: byte-serial checksum over three polynomials with a register port
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "crce_regs.vh"

// How it works
// RL1 - the mode register picks one of three generator polynomials and the byte step uses it.
// RL2 - the ccitt selection divides by the sixteen bit polynomial with terms 16, 12, 5 and 0.
// RL3 - the crc16 selection divides by the sixteen bit polynomial with terms 16, 15, 2 and 0.
// RL4 - the crc32 selection divides by the standard thirty-two bit ethernet polynomial.
// RL5 - input data and the sum each have their own bit reverse and complement options.
// RL6 - software writes the seed register to choose the starting value of the checksum.
// RL7 - data writes never wait, one further write is held aside, a write beyond that is dropped and sets the overrun flag.
// RL8 - a byte write is folded into the checksum on the next clock edge.
// RL9 - a halfword write is folded in as two byte steps over two clock edges.
// RL10 - a word write is folded in as four byte steps over four clock edges.
// RL11 - bytes of a wider write enter the calculation lowest byte first.
// RL12 - a seed write reloads the checksum state and drops any bytes still waiting.

module crce_engine
(
  input wire ref_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [1:0] reg_size,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);

////////////////////////////////////////////////////////////////////////////////
// functions

// trim a value to the width of the selected polynomial
function [31:0] crce_trim;
  input [31:0] w;
  input wide;
  begin
    crce_trim = wide ? w : (w & `CRCE_MASK16);
  end
endfunction

// one byte step of the shift division, msb first
function [31:0] crce_byte_step;
  input [31:0] st;
  input [7:0] d;
  input [1:0] sel;
  reg [31:0] s;
  reg [31:0] poly;
  reg fb;
  integer i;
  begin
    s = st;
    fb = 1'b0;
    // choose the generator [RL1]
    case (sel)
      `CRCE_SEL_CCITT: poly = `CRCE_POLY_CCITT; // [RL2]
      `CRCE_SEL_CRC16: poly = `CRCE_POLY_CRC16; // [RL3]
      default: poly = `CRCE_POLY_CRC32; // [RL4]
    endcase
    for (i = 0; i < `CRCE_BYTE_W; i = i + 1)
    begin
      if (sel[1])
      begin
        fb = s[`CRCE_TOP32] ^ d[`CRCE_BYTE_W - 1 - i];
        s = {s[30:0], 1'b0} ^ (fb ? poly : `CRCE_ZERO32);
      end
      else
      begin
        fb = s[`CRCE_TOP16] ^ d[`CRCE_BYTE_W - 1 - i];
        s = crce_trim({s[30:0], 1'b0} ^ (fb ? poly : `CRCE_ZERO32), 1'b0);
      end
    end
    crce_byte_step = s;
  end
endfunction

// reverse the bit order inside each byte of a word
function [31:0] crce_rev_bytes;
  input [31:0] w;
  integer i;
  begin
    crce_rev_bytes = `CRCE_ZERO32;
    for (i = 0; i < 32; i = i + 1)
    begin
      crce_rev_bytes[(i / 8) * 8 + 7 - (i % 8)] = w[i];
    end
  end
endfunction

// reverse the bit order of a sixteen bit value in the low half
function [31:0] crce_rev16;
  input [31:0] w;
  integer i;
  begin
    crce_rev16 = `CRCE_ZERO32;
    for (i = 0; i < 16; i = i + 1)
    begin
      crce_rev16[15 - i] = w[i];
    end
  end
endfunction

// reverse the bit order of a full word
function [31:0] crce_rev32;
  input [31:0] w;
  integer i;
  begin
    crce_rev32 = `CRCE_ZERO32;
    for (i = 0; i < 32; i = i + 1)
    begin
      crce_rev32[31 - i] = w[i];
    end
  end
endfunction

// number of byte steps for a write size
function [2:0] crce_size_cnt;
  input [1:0] size;
  begin
    case (size)
      `CRCE_SIZE_BYTE: crce_size_cnt = `CRCE_CNT_BYTE;
      `CRCE_SIZE_HALF: crce_size_cnt = `CRCE_CNT_HALF;
      default: crce_size_cnt = `CRCE_CNT_WORD;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// state

reg [`CRCE_MODE_W-1:0] mode_r;
reg [31:0] seed_r;
reg [31:0] state_r;
reg [31:0] cur_data_r;
reg [2:0] cur_cnt_r;
reg [31:0] pend_data_r;
reg [2:0] pend_cnt_r;
reg pend_vld_r;
reg ovr_r;

reg [31:0] state_nxt;
reg [31:0] cur_data_nxt;
reg [2:0] cur_cnt_nxt;
reg [31:0] pend_data_nxt;
reg [2:0] pend_cnt_nxt;
reg pend_vld_nxt;
reg ovr_nxt;
reg [31:0] rdata_nxt;

wire [1:0] sel = mode_r[`CRCE_MODE_SEL_HI:`CRCE_MODE_SEL_LO];
wire wr_mode = reg_wr && (reg_addr == `CRCE_OFF_MODE);
wire wr_seed = reg_wr && (reg_addr == `CRCE_OFF_SEED);
wire wr_data = reg_wr && (reg_addr == `CRCE_OFF_DATA);
wire wr_status = reg_wr && (reg_addr == `CRCE_OFF_STATUS);
wire busy = (cur_cnt_r != `CRCE_CNT_ZERO);
wire last_step = (cur_cnt_r == `CRCE_CNT_ONE);
wire can_start = !busy || last_step; // no write in progress, or the current write ends at this edge
wire [7:0] cur_byte = cur_data_r[`CRCE_BYTE_W-1:0]; // lowest byte still waiting

////////////////////////////////////////////////////////////////////////////////
// data path

// input data after the programmed complement and bit reversal
reg [31:0] din;
always @*
begin
  din = reg_wdata;
  if (mode_r[`CRCE_MODE_CMPL_IN])
  begin
    din = ~din; // [RL5]
  end
  if (mode_r[`CRCE_MODE_REV_IN])
  begin
    din = crce_rev_bytes(din); // [RL5]
  end
end

// sum as software sees it once this edge's byte step is done, trimmed to width
reg [31:0] sum;
always @*
begin
  sum = crce_trim(state_nxt, sel[1]); // [RL8]
  if (mode_r[`CRCE_MODE_REV_SUM])
  begin
    sum = sel[1] ? crce_rev32(sum) : crce_rev16(sum); // [RL5]
  end
  if (mode_r[`CRCE_MODE_CMPL_SUM])
  begin
    sum = crce_trim(~sum, sel[1]); // [RL5]
  end
end

// status word as it stands once this edge's byte step is done
reg [31:0] status_word;
always @*
begin
  status_word = `CRCE_ZERO32;
  status_word[`CRCE_ST_BUSY] = (cur_cnt_nxt != `CRCE_CNT_ZERO); // [RL8] [RL9] [RL10]
  status_word[`CRCE_ST_PEND] = pend_vld_nxt;
  status_word[`CRCE_ST_OVR] = ovr_nxt;
end

// mode register widened to the bus, upper bits zero
reg [31:0] mode_word;
always @*
begin
  mode_word = `CRCE_ZERO32;
  mode_word[`CRCE_MODE_W-1:0] = mode_r;
end

////////////////////////////////////////////////////////////////////////////////
// byte sequencer and write acceptance

always @*
begin
  state_nxt = state_r;
  cur_data_nxt = cur_data_r;
  cur_cnt_nxt = cur_cnt_r;
  pend_data_nxt = pend_data_r;
  pend_cnt_nxt = pend_cnt_r;
  pend_vld_nxt = pend_vld_r;
  ovr_nxt = ovr_r;
  // one byte step per cycle, lowest byte first
  if (busy)
  begin
    state_nxt = crce_byte_step(state_r, cur_byte, sel); // [RL8] [RL9] [RL10]
    cur_data_nxt = {8'h00, cur_data_r[31:8]}; // [RL11]
    cur_cnt_nxt = cur_cnt_r - `CRCE_CNT_ONE;
  end
  // held write starts as soon as the current one ends
  if (can_start && pend_vld_r)
  begin
    cur_data_nxt = pend_data_r;
    cur_cnt_nxt = pend_cnt_r;
    pend_vld_nxt = 1'b0;
  end
  // new data write: start now, or hold it, or flag the overrun
  if (wr_data)
  begin
    if (can_start && !pend_vld_r)
    begin
      cur_data_nxt = din; // [RL7]
      cur_cnt_nxt = crce_size_cnt(reg_size);
    end
    else if (!pend_vld_r || can_start)
    begin
      pend_data_nxt = din; // [RL7]
      pend_cnt_nxt = crce_size_cnt(reg_size);
      pend_vld_nxt = 1'b1;
    end
    else
    begin
      ovr_nxt = 1'b1;
    end
  end
  // clearing the overrun by writing one; a new overrun wins
  if (wr_status && reg_wdata[`CRCE_ST_OVR] && !(ovr_nxt && !ovr_r))
  begin
    ovr_nxt = 1'b0;
  end
  // seed write restarts from the seed and drops queued bytes
  if (wr_seed)
  begin
    state_nxt = reg_wdata; // [RL6] [RL12]
    cur_cnt_nxt = `CRCE_CNT_ZERO; // [RL12]
    pend_vld_nxt = 1'b0; // [RL12]
  end
end

////////////////////////////////////////////////////////////////////////////////
// read decode, answered one cycle after the strobe

always @*
begin
  rdata_nxt = `CRCE_ZERO32;
  if (reg_rd)
  begin
    case (reg_addr)
      `CRCE_OFF_MODE: rdata_nxt = mode_word;
      `CRCE_OFF_SEED: rdata_nxt = seed_r;
      `CRCE_OFF_SUM: rdata_nxt = sum;
      `CRCE_OFF_STATUS: rdata_nxt = status_word;
      default: rdata_nxt = `CRCE_ZERO32;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// registers

// mode and seed storage
always @(posedge ref_clk)
begin
  if (!reset_n)
  begin
    mode_r <= `CRCE_MODE_RST;
    seed_r <= `CRCE_SEED_RST;
  end
  else
  begin
    if (wr_mode)
    begin
      mode_r <= reg_wdata[`CRCE_MODE_W-1:0]; // [RL1] [RL5]
    end
    if (wr_seed)
    begin
      seed_r <= reg_wdata; // [RL6]
    end
  end
end

// checksum state, byte queue and status
always @(posedge ref_clk)
begin
  if (!reset_n)
  begin
    state_r <= `CRCE_SEED_RST;
    cur_data_r <= `CRCE_ZERO32;
    cur_cnt_r <= `CRCE_CNT_ZERO;
    pend_data_r <= `CRCE_ZERO32;
    pend_cnt_r <= `CRCE_CNT_ZERO;
    pend_vld_r <= 1'b0;
    ovr_r <= 1'b0;
    reg_rdata <= `CRCE_ZERO32;
  end
  else
  begin
    state_r <= state_nxt;
    cur_data_r <= cur_data_nxt;
    cur_cnt_r <= cur_cnt_nxt;
    pend_data_r <= pend_data_nxt;
    pend_cnt_r <= pend_cnt_nxt;
    pend_vld_r <= pend_vld_nxt;
    ovr_r <= ovr_nxt;
    reg_rdata <= rdata_nxt; // read data valid only in the cycle after the strobe
  end
end

endmodule

`default_nettype wire

// file: crce_engine_properties.sv
// assertions on the register port of the crc engine
`timescale 1ns/1ps
`default_nettype none
`include "crce_regs.vh"
module crce_chk
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_size,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  logic [5:0] m_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // decoded strobes
  wire ws = reg_wr && reg_addr == `CRCE_OFF_SEED;
  wire wd = reg_wr && reg_addr == `CRCE_OFF_DATA;
  wire ww = wd && reg_size[1];
  wire rs = reg_rd && reg_addr == `CRCE_OFF_STATUS;
  wire rc = reg_rd && reg_addr == `CRCE_OFF_SUM;
  // shadow of the mode register
  always @(posedge ref_clk)
    if (!reset_n)
      m_r <= 6'h00;
    else if (reg_wr && reg_addr == `CRCE_OFF_MODE)
      m_r <= reg_wdata[5:0];
  property p_mode;
    reg_rd && reg_addr == `CRCE_OFF_MODE |=> reg_rdata == {26'h0, m_r};
  endproperty
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  property p_seed;
    ws ##1 reg_rd && reg_addr == `CRCE_OFF_SEED |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_seed: assert property (p_seed) else $error("seed readback wrong");
  property p_ssum;
    ws && m_r[5:4] == 2'h0 ##1 rc |=>
      reg_rdata == ($past(reg_wdata, 2) & (m_r[1] ? 32'hFFFFFFFF : 32'h0000FFFF));
  endproperty
  a_ssum: assert property (p_ssum) else $error("sum not reloaded by seed");
  property p_byte;
    ws ##1 wd && reg_size == 2'h0 ##1 rs |=> !reg_rdata[0];
  endproperty
  a_byte: assert property (p_byte) else $error("byte write not done in one cycle");
  property p_half;
    ws ##1 wd && reg_size == 2'h1 ##1 rs |=> reg_rdata[0];
  endproperty
  a_half: assert property (p_half) else $error("halfword write done too soon");
  property p_wbusy;
    ws ##1 ww ##1 rs |=> reg_rdata[0];
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("word write done too soon");
  property p_wdone;
    ws ##1 ww ##1 !reg_wr [*3] ##1 rs |=> !reg_rdata[0];
  endproperty
  a_wdone: assert property (p_wdone) else $error("word write not done in four");
  property p_ovr;
    ws ##1 ww ##1 wd ##1 wd ##1 rs |=> reg_rdata[2];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
endmodule
bind crce_engine crce_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));
`default_nettype wire

// file: crce_engine_tb.sv
// self-checking bench of the crc engine against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`include "crce_regs.vh"
module crce_engine_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  wire [7:0] reg_addr;
  wire [31:0] reg_wdata;
  wire [1:0] reg_size;
  wire reg_wr;
  wire reg_rd;
  wire [31:0] reg_rdata;
  logic [31:0] st;
  logic [31:0] q;
  logic [5:0] md;
  integer fails = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer seed = 32'h4E24;
  integer i;
  integer k;
  crce_engine uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  crce_host h (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // 8 ns clock
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      fails = fails + 1;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////
  // model byte step, msb first, non-reflected
  function [31:0] stp(input [31:0] s, input [7:0] b);
    integer j;
    begin
      if (md[2])
        b = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      s = md[1] ? s ^ {b, 24'h000000} : s ^ {16'h0000, b, 8'h00};
      for (j = 0; j < 8; j = j + 1)
        s = md[1] ? {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0) :
          {16'h0, s[14:0], 1'b0} ^ (s[15] ? (md[0] ? 32'h8005 : 32'h1021) : 32'h0);
      stp = s;
    end
  endfunction
  // model sum with its output options
  function [31:0] fin(input [31:0] s);
    integer j;
    begin
      fin = s;
      if (md[4])
        for (j = 0; j < 32; j = j + 1)
          fin[j] = md[1] ? s[31 - j] : (j < 16 ? s[15 - j] : 1'b0);
      if (md[5])
        fin = ~fin;
      if (!md[1])
        fin = fin & 32'h0000FFFF;
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        fails = fails + 1;
      end
    end
  endtask
  task ck(input [7:0] a, input [31:0] e);
    logic [31:0] r;
    begin
      h.rd(a, r);
      chk(r, e);
    end
  endtask
  // data write into design and model, lowest byte first
  task feed(input [1:0] sz, input [31:0] d);
    integer j;
    begin
      h.wr(`CRCE_OFF_DATA, d, sz);
      if (md[3])
        d = ~d;
      for (j = 0; j < (sz == 2'h0 ? 1 : sz == 2'h1 ? 2 : 4); j = j + 1)
        st = stp(st, d[8 * j +: 8]);
    end
  endtask
  task seed_to(input [31:0] v);
    begin
      h.wr(`CRCE_OFF_SEED, v, 2'h0);
      st = v;
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    h.idle(2);
    md = 6'h00;
    st = 32'hFFFFFFFF;
    ck(`CRCE_OFF_MODE, 32'h0);
    ck(`CRCE_OFF_SEED, 32'hFFFFFFFF);
    ck(`CRCE_OFF_SUM, fin(st));
    h.wr(8'h14, 32'h5A5A5A5A, 2'h0);
    ck(8'h14, 32'h0);
    ck(`CRCE_OFF_DATA, 32'h0);
    $display("reset test done");
    // every selection with random options, seeds and sizes
    for (i = 0; i < 24; i = i + 1)
    begin
      md = 6'($random(seed));
      md[1:0] = i[1:0];
      h.wr(`CRCE_OFF_MODE, {26'h0, md}, 2'h0);
      ck(`CRCE_OFF_MODE, {26'h0, md});
      q = $random(seed);
      seed_to(q);
      ck(`CRCE_OFF_SEED, q);
      for (k = 0; k < 3; k = k + 1)
      begin
        feed(2'($random(seed)), $random(seed));
        h.idle(3);
      end
      ck(`CRCE_OFF_SUM, fin(st));
    end
    $display("polynomial test done");
    md = 6'h00;
    h.wr(`CRCE_OFF_MODE, 32'h0, 2'h0);
    q = $random(seed);
    seed_to(q);
    ck(`CRCE_OFF_SUM, fin(st));
    seed_to(q);
    feed(2'h0, q);
    ck(`CRCE_OFF_SUM, fin(st));
    seed_to(q);
    feed(2'h0, q);
    ck(`CRCE_OFF_STATUS, 32'h0);
    seed_to(q);
    feed(2'h1, q);
    ck(`CRCE_OFF_STATUS, 32'h1);
    seed_to(q);
    feed(2'h2, q);
    ck(`CRCE_OFF_STATUS, 32'h1);
    seed_to(q);
    feed(2'h2, q);
    h.idle(3);
    ck(`CRCE_OFF_STATUS, 32'h0);
    feed(2'h2, q);
    seed_to(~q);
    ck(`CRCE_OFF_SUM, fin(st));
    $display("timing test done");
    seed_to(q);
    feed(2'h2, q);
    feed(2'h0, ~q);
    h.wr(`CRCE_OFF_DATA, q, 2'h0);
    h.rd(`CRCE_OFF_STATUS, q);
    chk(q, 32'h7);
    h.idle(4);
    ck(`CRCE_OFF_SUM, fin(st));
    h.wr(`CRCE_OFF_STATUS, 32'h4, 2'h0);
    ck(`CRCE_OFF_STATUS, 32'h0);
    $display("overrun test done");
    test_done;
  end
endmodule
`default_nettype wire

// file: crce_host.sv
// bus master model standing in for the processor or dma writer
`timescale 1ns/1ps
`default_nettype none
module crce_host
(
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic [1:0] reg_size,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // bus quiet at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_size = 2'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write strobe per cycle, back to back allowed, no polling
  task wr(input [7:0] a, input [31:0] d, input [1:0] s);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_size <= s;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // read strobe, data taken one cycle later; released data lines flip
  task rd(input [7:0] a, output [31:0] q);
    begin
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_wdata <= ~reg_wdata;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      q = reg_rdata;
    end
  endtask
  // idle cycles with strobes low
  task idle(input integer n);
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_wdata <= ~reg_wdata;
      repeat (n) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: crce_regs.vh
// register map, field positions, reset values and polynomials of the crc engine
`ifndef CRCE_REGS_VH
`define CRCE_REGS_VH

// register byte offsets
`define CRCE_OFF_MODE 8'h00
`define CRCE_OFF_SEED 8'h04
`define CRCE_OFF_SUM 8'h08
`define CRCE_OFF_DATA 8'h0C
`define CRCE_OFF_STATUS 8'h10

// mode register fields
`define CRCE_MODE_SEL_LO 0
`define CRCE_MODE_SEL_HI 1
`define CRCE_MODE_REV_IN 2
`define CRCE_MODE_CMPL_IN 3
`define CRCE_MODE_REV_SUM 4
`define CRCE_MODE_CMPL_SUM 5
`define CRCE_MODE_W 6
`define CRCE_MODE_RST 6'h00

// polynomial selections
`define CRCE_SEL_CCITT 2'h0
`define CRCE_SEL_CRC16 2'h1
`define CRCE_SEL_CRC32 2'h2

// generator polynomials, top term implied
`define CRCE_POLY_CCITT 32'h00001021
`define CRCE_POLY_CRC16 32'h00008005
`define CRCE_POLY_CRC32 32'h04C11DB7

// seed and state reset value
`define CRCE_SEED_RST 32'hFFFFFFFF

// status register fields
`define CRCE_ST_BUSY 0
`define CRCE_ST_PEND 1
`define CRCE_ST_OVR 2

// write size codes
`define CRCE_SIZE_BYTE 2'h0
`define CRCE_SIZE_HALF 2'h1
`define CRCE_SIZE_WORD 2'h2

// byte counts and field widths
`define CRCE_CNT_BYTE 3'h1
`define CRCE_CNT_HALF 3'h2
`define CRCE_CNT_WORD 3'h4
`define CRCE_CNT_ZERO 3'h0
`define CRCE_CNT_ONE 3'h1
`define CRCE_MASK16 32'h0000FFFF
`define CRCE_ZERO32 32'h00000000
`define CRCE_BYTE_W 8
`define CRCE_TOP16 15
`define CRCE_TOP32 31

`endif
